/* File: pkg/ddmr_defs.vh */
// ddmr_defs.vh - constants for the mode register and burst block
// assumes inclusion by bare name from design files; definitions only
`ifndef DDMR_DEFS_VH
`define DDMR_DEFS_VH

// mode register field positions (address pin numbers)
`define DDMR_BL_LO 0
`define DDMR_BL_HI 1
`define DDMR_BT_BIT 3
`define DDMR_DLLRST_BIT 8
`define DDMR_WR_LO 9
`define DDMR_WR_HI 11
`define DDMR_PPD_BIT 12
`define DDMR_DLLDIS_BIT 0
`define DDMR_AL_LO 3
`define DDMR_AL_HI 4
`define DDMR_QOFF_BIT 12
`define DDMR_TDQS_BIT 11
`define DDMR_BC_BIT 12
`define DDMR_AP_BIT 10
`define DDMR_MR_W 13

// burst length field codes
`define DDMR_BL_8 2'h0
`define DDMR_BL_OTF 2'h1
`define DDMR_BL_4 2'h2

// additive latency codes
`define DDMR_AL_0 2'h0
`define DDMR_AL_CL1 2'h1
`define DDMR_AL_CL2 2'h2

// bank address of each mode register
`define DDMR_BA_MR0 3'h0
`define DDMR_BA_MR1 3'h1

// command encodings {cs_n, ras_n, cas_n, we_n}
`define DDMR_CMD_MRS 4'h0
`define DDMR_CMD_REF 4'h1
`define DDMR_CMD_WR 4'h4
`define DDMR_CMD_RD 4'h5

// burst counts in beats, timing counts in link clocks
`define DDMR_BEATS 4'h8
`define DDMR_CHOP_BEATS 4'h4
`define DDMR_WREF_BL8 6'h04
`define DDMR_WREF_BC4 6'h02
`define DDMR_TRP_CK 6'h0E
`define DDMR_RST_MR0 13'h0000
`define DDMR_RST_MR1 13'h0000

// write recovery codes to clocks
`define DDMR_WR_C0 6'h10
`define DDMR_WR_C1 6'h05
`define DDMR_WR_C2 6'h06
`define DDMR_WR_C3 6'h07
`define DDMR_WR_C4 6'h08
`define DDMR_WR_C5 6'h0A
`define DDMR_WR_C6 6'h0C
`define DDMR_WR_C7 6'h0E

`endif

/* File: tb/ddmr_ctl.sv */
// ddmr_ctl - command side of a memory controller for the bench
// assumes the bench calls cmd and samples the burst beats itself
`timescale 1ns/1ps
`default_nettype none
module ddmr_ctl (
  output logic o_ck,
  output logic o_cke,
  output logic [3:0] o_cmd,
  output logic [2:0] o_ba,
  output logic [15:0] o_addr,
  output logic [7:0] o_dq
);
  initial begin
    o_ck = 1'b0;
    o_cke = 1'b1;
    o_cmd = 4'hF;
    o_ba = 3'h0;
    o_addr = 16'h0000;
    o_dq = 8'h00;
  end
  // link clock runs free; edges fall on system clock falling edges
  always #40 o_ck = ~o_ck;
  // write data centred in each beat, new value every half clock
  always @(o_ck) o_dq <= #16 o_dq + 8'h01;
  // one command across one rising edge, then deselect with address inverted
  task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [15:0] a,
      input logic e);
    @(negedge o_ck);
    o_cmd = c;
    o_ba = b;
    o_addr = a;
    o_cke = e;
    @(negedge o_ck);
    o_cmd = 4'hF;
    o_addr = ~a;
  endtask
endmodule // ddmr_ctl
`default_nettype wire

/* File: tb/ddmr_monitor.sv */
// ddmr_monitor - port assertions for the mode register and burst block
// assumes it is bound onto ddmr_core and sees only its ports
`timescale 1ns/1ps
`default_nettype none
`include "ddmr_defs.vh"
module ddmr_monitor (
  input wire i_clk_sys,
  input wire i_rstn,
  input wire o_dq_oe,
  input wire o_dqs,
  input wire o_dqs_oe,
  input wire o_tdqs_oe,
  input wire o_tdqs_n_oe,
  input wire o_wr_valid,
  input wire o_wr_ref,
  input wire o_auto_pre,
  input wire [`DDMR_MR_W-1:0] o_mr0,
  input wire [`DDMR_MR_W-1:0] o_mr1,
  input wire o_dll_reset,
  input wire o_dll_on,
  input wire o_self_refresh,
  input wire o_power_down
);
  // settle count: outputs still show reset values for a few edges
  reg [1:0] up;
  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      up <= 2'h0;
    end else if (up != 2'h3) begin
      up <= up + 2'h1;
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  a_qoff_floats: assert property (o_mr1[12] |-> !(o_dq_oe || o_dqs_oe || o_tdqs_oe))
    else $error("output driven while disabled");
  a_tdqs_off_hiz: assert property (!o_mr1[11] |-> !o_tdqs_oe && !o_tdqs_n_oe)
    else $error("strobe pins driven with mask mode");
  a_strobe_pair: assert property (o_dq_oe == o_dqs_oe)
    else $error("data and strobe enables differ");
  a_beat_holds: assert property (o_dqs_oe && $changed(o_dqs) |=>
      ($stable(o_dqs) || !o_dqs_oe) [*3])
    else $error("beat shorter than half a link clock");
  a_dll_rst_clear: assert property (o_dll_reset |=> !o_dll_reset && !o_mr0[8])
    else $error("dll reset bit did not clear");
  a_dll_state_eq: assert property (up == 2'h3 && $stable(o_mr1[0]) && $stable(o_mr0[12])
      && $stable(o_self_refresh) && $stable(o_power_down) |-> o_dll_on ==
      (!o_mr1[0] && !o_self_refresh && !(o_power_down && !o_mr0[12])))
    else $error("dll state wrong");
  a_wr_ref_time: assert property (o_wr_ref |-> ((o_mr0[1:0] == `DDMR_BL_4) ?
      $past(o_wr_valid, 19) : $past(o_wr_valid, 39)))
    else $error("write reference point misplaced");
  a_no_rd_in_wr: assert property (o_wr_valid |-> !o_dq_oe)
    else $error("read drivers on during write");
  c_read: cover property ($rose(o_dq_oe));
  c_wref: cover property (o_wr_ref);
  c_apre: cover property (o_auto_pre);
  c_sref: cover property ($rose(o_self_refresh));
endmodule // ddmr_monitor
bind ddmr_core ddmr_monitor u_mon (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
  .o_dq_oe(o_dq_oe), .o_dqs(o_dqs), .o_dqs_oe(o_dqs_oe), .o_tdqs_oe(o_tdqs_oe),
  .o_tdqs_n_oe(o_tdqs_n_oe), .o_wr_valid(o_wr_valid), .o_wr_ref(o_wr_ref),
  .o_auto_pre(o_auto_pre), .o_mr0(o_mr0), .o_mr1(o_mr1), .o_dll_reset(o_dll_reset),
  .o_dll_on(o_dll_on), .o_self_refresh(o_self_refresh), .o_power_down(o_power_down));
`default_nettype wire

/* File: tb/tb_top.sv */
// tb_top - directed bench for the mode register and burst block
// assumes the controller model drives pins and the bench feeds read words
`timescale 1ns/1ps
`default_nettype none
`include "ddmr_defs.vh"
module tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] rd_data = 8'h00;
  logic rd_valid = 1'b0;
  logic saw_rst = 1'b0;
  logic dm = 1'b0;
  logic [7:0] wlast = 8'h00;
  logic [2:0] cols [8];
  wire ck, cke, rd_ready, dq_oe, dqs, dqs_oe, tdqs_oe, wr_valid, wr_ref, apre;
  wire dll_rst, dll_on, sref, pd, wmask, tdqs;
  wire [3:0] cmd;
  wire [2:0] ba, wcol;
  wire [15:0] addr;
  wire [7:0] dq, q, wdat;
  wire [12:0] mr0, mr1;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int nw = 0;
  int t_ref = 0;
  int t_ap = 0;
  int nstep = 0;
  int nmask = 0;
  ddmr_ctl u_ctl (.o_ck(ck), .o_cke(cke), .o_cmd(cmd), .o_ba(ba), .o_addr(addr), .o_dq(dq));
  ddmr_core #(.TRP_CK(6'h02)) u_dut (.i_clk_sys(clk), .i_rstn(rstn), .i_ce(1'b1),
    .i_ck(ck), .i_cke(cke), .i_cs_n(cmd[3]), .i_ras_n(cmd[2]), .i_cas_n(cmd[1]),
    .i_we_n(cmd[0]), .i_ba(ba), .i_addr(addr), .i_dq(dq), .i_dm(dm),
    .i_cas_lat(5'h05), .i_cas_wr_lat(5'h05), .i_rd_data(rd_data), .i_rd_valid(rd_valid),
    .o_rd_ready(rd_ready), .o_dq(q), .o_dq_oe(dq_oe), .o_dqs(dqs), .o_dqs_oe(dqs_oe),
    .o_tdqs(tdqs), .o_tdqs_oe(tdqs_oe), .o_tdqs_n(), .o_tdqs_n_oe(), .o_wr_data(wdat),
    .o_wr_col(wcol), .o_wr_mask(wmask), .o_wr_valid(wr_valid), .o_wr_ref(wr_ref),
    .o_auto_pre(apre), .o_mr0(mr0), .o_mr1(mr1), .o_dll_reset(dll_rst),
    .o_dll_on(dll_on), .o_self_refresh(sref), .o_power_down(pd));
  always #4 clk = ~clk;
  // log write beats and pulse times; ceiling cuts a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wr_valid === 1'b1) begin
      cols[nw % 8] <= wcol;
      nw <= nw + 1;
      wlast <= wdat;
      // data steps by one per beat; nibble starts are skipped
      if (wcol[1:0] != 2'h0 && wdat == wlast + 8'h01) nstep <= nstep + 1;
      if (wmask === 1'b1) nmask <= nmask + 1;
    end
    if (dll_rst === 1'b1) saw_rst <= 1'b1;
    if (wr_ref === 1'b1) t_ref <= cyc;
    if (apre === 1'b1) t_ap <= cyc;
    if (cyc == 30000) begin
      bad_count++;
      end_of_test;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic mrs(input logic [2:0] b, input logic [12:0] v);
    u_ctl.cmd(`DDMR_CMD_MRS, b, {3'h0, v}, 1'b1);
    repeat (4) @(negedge clk);
  endtask
  // one word into the read fifo, held until ready is seen
  task automatic push(input logic [7:0] d);
    @(negedge clk);
    rd_data = d;
    rd_valid = 1'b1;
    // ready is registered, so its value here is what the next edge samples
    for (int k = 0; k < 50 && rd_ready !== 1'b1; k++) @(negedge clk);
    @(negedge clk);
    rd_valid = 1'b0;
  endtask
  // reset values, dll reset self-clear, both mode registers written
  task automatic t_mrs;
    chk({mr0, mr1}, 26'h0);
    mrs(`DDMR_BA_MR1, 13'h0000);
    mrs(`DDMR_BA_MR0, 13'h1108);
    repeat (20) @(negedge clk);
    chk(saw_rst, 1'b1);
    chk(mr0, 13'h1008);
    mrs(`DDMR_BA_MR1, 13'h0808);
    chk(mr1, 13'h0808);
  endtask
  // one read burst: preload the fifo, check enable, strobe and word per beat
  task automatic t_read(input logic [12:0] m0, input logic [12:0] m1, input logic bc,
      input logic [2:0] s);
    logic chop;
    logic [2:0] c;
    int rl;
    chop = (m0[1:0] == `DDMR_BL_4) || (m0[1:0] == `DDMR_BL_OTF && !bc);
    rl = 5 + ((m1[4:3] == `DDMR_AL_CL1) ? 4 : (m1[4:3] == `DDMR_AL_CL2) ? 3 : 0);
    mrs(`DDMR_BA_MR1, m1);
    mrs(`DDMR_BA_MR0, m0);
    for (int k = 0; k < (chop ? 4 : 8); k++) push({5'h14, chop ? {s[2], k[1:0]} : k[2:0]});
    chk(rd_ready, chop); // full fifo refuses
    u_ctl.cmd(`DDMR_CMD_RD, 3'h0, {3'h0, bc, 9'h000, s}, 1'b1);
    repeat (rl) @(posedge ck);
    #14;
    for (int n = 0; n < 8; n++) begin
      #40;
      c = m0[3] ? s ^ n[2:0] : {s[2] ^ n[2], s[1:0] + n[1:0]};
      chk(dq_oe, !m1[12] && !(chop && n > 3));
      if (dq_oe === 1'b1) chk({dqs, q}, {~n[0], 5'h14, c});
      if (m1[11]) chk({tdqs_oe, tdqs}, {dq_oe, ~n[0]});
    end
    repeat (3) @(posedge ck);
  endtask
  // write with auto precharge: natural column order and precharge delay
  task automatic t_write(input logic [12:0] m0, input logic bc, input logic [2:0] s);
    logic chop;
    int n0;
    int p0;
    int q0;
    chop = (m0[1:0] == `DDMR_BL_4) || (m0[1:0] == `DDMR_BL_OTF && !bc);
    mrs(`DDMR_BA_MR0, m0); // recovery code 1 covers the bench timing
    n0 = nw;
    p0 = nstep;
    q0 = nmask;
    // mask pin held high; mask mode is active since MR1 A11 is 0 here
    @(negedge clk);
    dm = 1'b1;
    u_ctl.cmd(`DDMR_CMD_WR, 3'h0, {3'h0, bc, 2'h1, 7'h00, s}, 1'b1);
    repeat (20) @(posedge ck);
    @(negedge clk);
    dm = 1'b0;
    chk(nw - n0, chop ? 4 : 8);
    for (int k = 0; k < nw - n0; k++) chk(cols[(n0 + k) % 8], chop ? {s[2], k[1:0]} : k[2:0]);
    chk(nstep - p0, chop ? 3 : 6);
    chk(nmask - q0, chop ? 4 : 8);
    chk(t_ap - t_ref, 70);
  endtask
  // self refresh, then power-down with slow and fast exit
  task automatic t_power;
    u_ctl.cmd(`DDMR_CMD_REF, 3'h0, 16'h0000, 1'b0);
    repeat (8) @(negedge clk);
    chk({sref, dll_on}, 2'h2);
    u_ctl.cmd(4'hF, 3'h0, 16'h0000, 1'b1);
    repeat (8) @(negedge clk);
    chk({sref, dll_on}, 2'h1);
    for (int f = 0; f < 2; f++) begin
      mrs(`DDMR_BA_MR0, {f[0], 12'h000});
      u_ctl.cmd(4'hF, 3'h0, 16'h0000, 1'b0);
      repeat (8) @(negedge clk);
      chk({pd, dll_on}, {1'b1, f[0]});
      u_ctl.cmd(4'hF, 3'h0, 16'h0000, 1'b1);
    end
    // dll-off mode keeps the nominal termination bits at zero
    mrs(`DDMR_BA_MR1, 13'h0001);
    chk(dll_on, 1'b0);
    mrs(`DDMR_BA_MR1, 13'h0000);
    chk(dll_on, 1'b1);
  endtask
  // reset for four cycles, then every scenario in turn
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    t_mrs;
    t_read(13'h0000, 13'h0000, 1'b1, 3'h1);
    t_read(13'h0008, 13'h0800, 1'b1, 3'h7);
    t_read(13'h0002, 13'h0008, 1'b1, 3'h5);
    t_read(13'h0009, 13'h0010, 1'b0, 3'h3);
    t_read(13'h0001, 13'h0000, 1'b1, 3'h2);
    t_read(13'h0000, 13'h1000, 1'b1, 3'h0);
    t_write(13'h0200, 1'b1, 3'h7);
    t_write(13'h0202, 1'b1, 3'h6);
    t_write(13'h0201, 1'b0, 3'h5);
    t_power;
    end_of_test;
  end
endmodule // tb_top
`default_nettype wire

/* File: verilog/ddmr_core.v */
// ddmr_core - mode registers, burst ordering, dll control of the sdram
// assumes pins arrive asynchronously and are sampled by i_clk_sys;
// the link clock runs far slower than i_clk_sys (several samples/phase)
// Operation
// R1 - A3 picks sequential or interleaved beat order
// R2 - A1:A0 pick chop4, fixed eight, or on-the-fly
// R3 - on-the-fly: A12 with command picks burst length
// R4 - read start column picks the first beat
// R5 - sequential: rotate in nibble, then other nibble
// R6 - interleaved: beat n is start xor n
// R7 - chop reads: four beats, then drivers off
// R8 - writes ignore low columns, natural order
// R9 - fixed chop pulls write reference in two clocks
// R10 - dll reset bit clears itself after use
// R11 - controller waits dll lock after reset
// R12 - write recovery plus precharge time auto precharge
// R13 - controller programs write recovery high enough
// R14 - A12 zero freezes dll in precharge powerdown
// R15 - A12 one keeps dll running in powerdown
// R16 - MR1 written when bank address is 001
// R17 - self refresh turns dll off, exit on
// R18 - controller keeps cke high during dll lock
// R19 - controller disables termination in dll-off mode
// R20 - controller limits termination choices in leveling
// R21 - commands held for additive latency internally
// R22 - output disable bit floats data and strobes
// R23 - A11 selects data mask or termination strobes
// R24 - MR0 written when bank address is 000
// R25 - length codes: 00 eight, 01 fly, 10 chop
`timescale 1ns/1ps
`default_nettype none
`include "ddmr_defs.vh"
module ddmr_core #(
  parameter DW = 8,
  parameter FD = 8,
  parameter FAW = 3,
  parameter [5:0] TRP_CK = `DDMR_TRP_CK
) (
  input wire i_clk_sys,
  input wire i_rstn,
  input wire i_ce,
  input wire i_ck,
  input wire i_cke,
  input wire i_cs_n,
  input wire i_ras_n,
  input wire i_cas_n,
  input wire i_we_n,
  input wire [2:0] i_ba,
  input wire [15:0] i_addr,
  input wire [DW-1:0] i_dq,
  input wire i_dm,
  input wire [4:0] i_cas_lat,
  input wire [4:0] i_cas_wr_lat,
  input wire [DW-1:0] i_rd_data,
  input wire i_rd_valid,
  output wire o_rd_ready,
  output reg [DW-1:0] o_dq,
  output reg o_dq_oe,
  output reg o_dqs,
  output reg o_dqs_oe,
  output reg o_tdqs,
  output reg o_tdqs_oe,
  output reg o_tdqs_n,
  output reg o_tdqs_n_oe,
  output reg [DW-1:0] o_wr_data,
  output reg [2:0] o_wr_col,
  output reg o_wr_mask,
  output reg o_wr_valid,
  output reg o_wr_ref,
  output reg o_auto_pre,
  output reg [`DDMR_MR_W-1:0] o_mr0,
  output reg [`DDMR_MR_W-1:0] o_mr1,
  output reg o_dll_reset,
  output reg o_dll_on,
  output reg o_self_refresh,
  output reg o_power_down
);
  localparam PW = DW + 26; // ck, cke, 4 command, 3 bank, 16 address, dq, dm
  localparam [3:0] S_IDLE = 4'h1;
  localparam [3:0] S_WAIT = 4'h2;
  localparam [3:0] S_RD = 4'h4;
  localparam [3:0] S_WR = 4'h8;

  // beat order inside a burst from start column and beat number
  function [2:0] f_order;
    input [2:0] start;
    input [2:0] n;
    input ilv;
    begin
      if (ilv) f_order = start ^ n; // R6
      else f_order = {start[2] ^ n[2], start[1:0] + n[1:0]}; // R5
    end
  endfunction

  // write recovery code to link clocks
  function [5:0] f_wr_ck;
    input [2:0] code;
    begin
      case (code)
        3'h1: f_wr_ck = `DDMR_WR_C1;
        3'h2: f_wr_ck = `DDMR_WR_C2;
        3'h3: f_wr_ck = `DDMR_WR_C3;
        3'h4: f_wr_ck = `DDMR_WR_C4;
        3'h5: f_wr_ck = `DDMR_WR_C5;
        3'h6: f_wr_ck = `DDMR_WR_C6;
        3'h7: f_wr_ck = `DDMR_WR_C7;
        default: f_wr_ck = `DDMR_WR_C0;
      endcase
    end
  endfunction

  // two-flop synchroniser for every pin; only s2 is read by logic
  reg [PW-1:0] s1;
  reg [PW-1:0] s2;
  reg ck_d;
  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      s1 <= {PW{1'b0}};
      s2 <= {PW{1'b0}};
      ck_d <= 1'b0;
    end else if (i_ce) begin
      s1 <= {i_ck, i_cke, i_cs_n, i_ras_n, i_cas_n, i_we_n, i_ba, i_addr, i_dq, i_dm};
      s2 <= s1;
      ck_d <= s2[PW-1];
    end
  end

  wire p_ck = s2[PW-1];
  wire p_cke = s2[PW-2];
  wire [3:0] p_cmd = s2[PW-3:PW-6];
  wire [2:0] p_ba = s2[PW-7:PW-9];
  wire [15:0] p_addr = s2[PW-10:PW-25];
  wire [DW-1:0] p_dq = s2[DW:1];
  wire p_dm = s2[0];
  wire ck_rise = p_ck & ~ck_d;
  wire ck_edge = p_ck ^ ck_d;
  wire cmd_ev = ck_rise & p_cke;

  // read data path fifo; user side stalls when it fills
  wire [DW-1:0] f_data;
  wire f_valid;
  reg f_take;
  ddmr_fifo #(.W(DW), .D(FD), .AW(FAW)) u_fifo (
    .i_clk(i_clk_sys),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_data(i_rd_data),
    .i_valid(i_rd_valid),
    .o_ready(o_rd_ready),
    .o_data(f_data),
    .o_valid(f_valid),
    .i_ready(f_take)
  );

  // decoded mode fields
  wire [1:0] bl_mode = o_mr0[`DDMR_BL_HI:`DDMR_BL_LO];
  wire ilv = o_mr0[`DDMR_BT_BIT];
  wire [1:0] al_code = o_mr1[`DDMR_AL_HI:`DDMR_AL_LO];
  wire qoff = o_mr1[`DDMR_QOFF_BIT];
  wire tdqs_en = o_mr1[`DDMR_TDQS_BIT];
  wire [4:0] al_ck = (al_code == `DDMR_AL_CL1) ? i_cas_lat - 5'h01 :
                     (al_code == `DDMR_AL_CL2) ? i_cas_lat - 5'h02 : 5'h00; // R21
  // chop chosen by fixed code or by A12 low in on-the-fly mode
  wire cmd_chop = (bl_mode == `DDMR_BL_4) |
                  ((bl_mode == `DDMR_BL_OTF) & ~p_addr[`DDMR_BC_BIT]); // R2 R3 R25

  reg [3:0] state;
  reg is_rd;
  reg chop;
  reg ap;
  reg [2:0] start;
  reg [5:0] lat_cnt;
  reg [3:0] beat;
  reg [3:0] ld_cnt;
  reg [5:0] wref_cnt;
  reg [5:0] ap_cnt;
  reg [DW-1:0] buf_mem [0:7];
  wire [3:0] nbeats = chop ? `DDMR_CHOP_BEATS : `DDMR_BEATS;
  wire [2:0] ld_col = {chop ? start[2] : ld_cnt[2], ld_cnt[1:0]};

  // pull the burst's words from the fifo while latency runs out;
  // words that have not arrived by the first beat are sent stale
  always @* begin
    f_take = (state == S_WAIT) & is_rd & (ld_cnt < nbeats) & f_valid;
  end

  always @(posedge i_clk_sys) begin
    if (i_ce & f_take) buf_mem[ld_col] <= f_data;
  end

  // mode registers, self refresh and power-down tracking
  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_mr0 <= `DDMR_RST_MR0;
      o_mr1 <= `DDMR_RST_MR1;
      o_dll_reset <= 1'b0;
      o_self_refresh <= 1'b0;
      o_power_down <= 1'b0;
      o_dll_on <= 1'b0;
    end else if (i_ce) begin
      o_dll_reset <= 1'b0;
      // reset bit is acted on once, then returns to zero
      if (o_mr0[`DDMR_DLLRST_BIT]) begin
        o_dll_reset <= 1'b1; // R10
        o_mr0[`DDMR_DLLRST_BIT] <= 1'b0; // R10
      end
      if (cmd_ev & (p_cmd == `DDMR_CMD_MRS) & (state == S_IDLE)) begin
        if (p_ba == `DDMR_BA_MR0) o_mr0 <= p_addr[`DDMR_MR_W-1:0]; // R24
        if (p_ba == `DDMR_BA_MR1) o_mr1 <= p_addr[`DDMR_MR_W-1:0]; // R16
      end
      if (ck_rise) begin
        // refresh with cke low enters self refresh; cke high leaves
        if (~p_cke & (p_cmd == `DDMR_CMD_REF) & ~o_power_down) o_self_refresh <= 1'b1;
        else if (p_cke) o_self_refresh <= 1'b0;
        o_power_down <= ~p_cke & ~o_self_refresh & (p_cmd != `DDMR_CMD_REF);
      end
      // dll follows enable bit, self refresh and slow-exit power-down
      o_dll_on <= ~o_mr1[`DDMR_DLLDIS_BIT] & ~o_self_refresh & // R17
                  ~(o_power_down & ~o_mr0[`DDMR_PPD_BIT]); // R14 R15
    end
  end

  // burst engine: one command at a time, others ignored while busy
  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= S_IDLE;
      is_rd <= 1'b0;
      chop <= 1'b0;
      ap <= 1'b0;
      start <= 3'h0;
      lat_cnt <= 6'h00;
      beat <= 4'h0;
      ld_cnt <= 4'h0;
      o_dq <= {DW{1'b0}};
      o_dq_oe <= 1'b0;
      o_dqs <= 1'b0;
      o_dqs_oe <= 1'b0;
      o_tdqs <= 1'b0;
      o_tdqs_oe <= 1'b0;
      o_tdqs_n <= 1'b0;
      o_tdqs_n_oe <= 1'b0;
      o_wr_data <= {DW{1'b0}};
      o_wr_col <= 3'h0;
      o_wr_mask <= 1'b0;
      o_wr_valid <= 1'b0;
    end else if (i_ce) begin
      o_wr_valid <= 1'b0;
      if (f_take) ld_cnt <= ld_cnt + 4'h1;
      case (state)
        S_IDLE: begin
          o_dq_oe <= 1'b0;
          o_dqs_oe <= 1'b0;
          o_tdqs_oe <= 1'b0;
          o_tdqs_n_oe <= 1'b0;
          if (cmd_ev & ((p_cmd == `DDMR_CMD_RD) | (p_cmd == `DDMR_CMD_WR))) begin
            state <= S_WAIT;
            is_rd <= (p_cmd == `DDMR_CMD_RD);
            chop <= cmd_chop;
            ap <= p_addr[`DDMR_AP_BIT];
            start <= p_addr[2:0]; // R4
            ld_cnt <= 4'h0;
            // held for additive latency, then cas or cas-write latency
            lat_cnt <= (p_cmd == `DDMR_CMD_RD) ? {1'b0, al_ck + i_cas_lat} :
                       {1'b0, al_ck + i_cas_wr_lat}; // R21
          end
        end
        S_WAIT: begin
          if (ck_rise) begin
            lat_cnt <= lat_cnt - 6'h01;
            if (lat_cnt <= 6'h01) begin
              beat <= 4'h0;
              state <= is_rd ? S_RD : S_WR;
            end
          end
        end
        S_RD: begin
          if (ck_edge | (beat == 4'h0)) begin
            if (beat == `DDMR_BEATS) begin
              state <= S_IDLE;
              o_dq_oe <= 1'b0;
              o_dqs_oe <= 1'b0;
              o_tdqs_oe <= 1'b0;
              o_tdqs_n_oe <= 1'b0;
            end else begin
              beat <= beat + 4'h1;
              o_dq <= buf_mem[f_order(start, beat[2:0], ilv)]; // R1
              // chop: last four slots float; qoff floats all
              o_dq_oe <= ~qoff & ~(chop & beat[2]); // R7 R22
              o_dqs_oe <= ~qoff & ~(chop & beat[2]); // R7 R22
              o_dqs <= ~beat[0];
              o_tdqs <= ~beat[0];
              o_tdqs_n <= beat[0];
              o_tdqs_oe <= ~qoff & tdqs_en & ~(chop & beat[2]); // R23
              o_tdqs_n_oe <= ~qoff & tdqs_en & ~(chop & beat[2]); // R23
            end
          end
        end
        S_WR: begin
          if (ck_edge | (beat == 4'h0)) begin
            if (beat == `DDMR_BEATS) begin
              state <= S_IDLE;
              o_tdqs_oe <= 1'b0;
              o_tdqs_n_oe <= 1'b0;
            end else begin
              beat <= beat + 4'h1;
              // natural order; only A2 kept, and only for chop
              o_wr_col <= {chop ? start[2] : beat[2], beat[1:0]}; // R8
              o_wr_data <= p_dq;
              o_wr_mask <= ~tdqs_en & p_dm; // R23
              o_wr_valid <= ~(chop & beat[2]); // R8
              o_tdqs <= ~beat[0];
              o_tdqs_n <= beat[0];
              o_tdqs_oe <= ~qoff & tdqs_en; // R23
              o_tdqs_n_oe <= ~qoff & tdqs_en; // R23
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // write reference point and auto precharge timers in link clocks
  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      wref_cnt <= 6'h00;
      ap_cnt <= 6'h00;
      o_wr_ref <= 1'b0;
      o_auto_pre <= 1'b0;
    end else if (i_ce) begin
      o_wr_ref <= 1'b0;
      o_auto_pre <= 1'b0;
      if ((state == S_WAIT) & ~is_rd & (wref_cnt == 6'h00) & ck_rise & (lat_cnt <= 6'h01)) begin
        // fixed chop starts the internal write two clocks sooner
        wref_cnt <= (bl_mode == `DDMR_BL_4) ? `DDMR_WREF_BC4 : `DDMR_WREF_BL8; // R9
      end else if (ck_rise & (wref_cnt != 6'h00)) begin
        wref_cnt <= wref_cnt - 6'h01;
        if (wref_cnt == 6'h01) begin
          o_wr_ref <= 1'b1; // R9
          if (ap) ap_cnt <= f_wr_ck(o_mr0[`DDMR_WR_HI:`DDMR_WR_LO]) + TRP_CK; // R12
        end
      end
      if (ck_rise & (ap_cnt != 6'h00)) begin
        ap_cnt <= ap_cnt - 6'h01;
        if (ap_cnt == 6'h01) o_auto_pre <= 1'b1; // R12
      end
    end
  end
endmodule // ddmr_core
`default_nettype wire

/* File: verilog/ddmr_fifo.v */
// ddmr_fifo - small synchronous fifo with valid/ready on both sides
// assumes one clock, async active-low reset, clock enable freezes state
`timescale 1ns/1ps
`default_nettype none
module ddmr_fifo #(
  parameter W = 8,
  parameter D = 8,
  parameter AW = 3
) (
  input wire i_clk,
  input wire i_rstn,
  input wire i_ce,
  input wire [W-1:0] i_data,
  input wire i_valid,
  output reg o_ready,
  output wire [W-1:0] o_data,
  output reg o_valid,
  input wire i_ready
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wp;
  reg [AW-1:0] rp;
  reg [AW:0] cnt;
  wire push = i_valid & o_ready;
  wire pop = o_valid & i_ready;
  reg [AW:0] next_cnt;

  assign o_data = mem[rp];

  always @* begin
    next_cnt = cnt;
    if (push & ~pop) next_cnt = cnt + 1'b1;
    else if (pop & ~push) next_cnt = cnt - 1'b1;
  end

  // full and empty are registered so both handshakes come from flops
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wp <= {AW{1'b0}};
      rp <= {AW{1'b0}};
      cnt <= {(AW+1){1'b0}};
      o_ready <= 1'b0;
      o_valid <= 1'b0;
    end else if (i_ce) begin
      if (push) begin
        mem[wp] <= i_data;
        wp <= (wp == D - 1) ? {AW{1'b0}} : wp + 1'b1;
      end
      if (pop) rp <= (rp == D - 1) ? {AW{1'b0}} : rp + 1'b1;
      cnt <= next_cnt;
      o_ready <= (next_cnt != D);
      o_valid <= (next_cnt != {(AW+1){1'b0}});
    end
  end
endmodule // ddmr_fifo
`default_nettype wire
